// ---- verilog/drsc_cfg.svh ----
// Constants for the dual-rank command and address port
`ifndef DRSC_CFG_SVH
`define DRSC_CFG_SVH
`define DRSC_RANKS 2
`define DRSC_BANKS 8
`define DRSC_ROW_W 16
`define DRSC_BANK_W 3
`define DRSC_COL_W 11
`define DRSC_AP_BIT 10
`define DRSC_BC_BIT 12
`define DRSC_COL_HI_BIT 11
`define DRSC_MR_COUNT 4
`define DRSC_MR0_BCOTF_LO 0
`define DRSC_MR0_BCOTF_HI 1
`define DRSC_MR0_BCOTF_VAL 2'h1
`define DRSC_MR0_RESET 16'h0000
`define DRSC_BL8 4'h8
`define DRSC_BC4 4'h4
`define DRSC_LAT_1866 5'h0D
`define DRSC_LAT_1600 5'h0B
`define DRSC_LAT_1333 5'h09
`define DRSC_REF_COUNT 8192
`define DRSC_REF_WIN_NORM_MS 64
`define DRSC_REF_WIN_HOT_MS 32
`endif

// ---- verilog/drsc_pkg.sv ----
// Types shared by the dual-rank command and address port
package drsc_pkg;
  // Decoded command, encoded as {ras_n,cas_n,we_n}
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_ZQ = 3'b110,
    CMD_NOP = 3'b111
  } drsc_cmd_e;
  // Power state of one rank
  typedef enum logic [2:0] {
    PS_ACTIVE = 3'b000,
    PS_PRE_PD = 3'b001,
    PS_ACT_PD = 3'b010,
    PS_SELF_REF = 3'b011
  } drsc_pwr_e;
  // Speed grade selector
  typedef enum logic [1:0] {
    GR_1333 = 2'b00,
    GR_1600 = 2'b01,
    GR_1866 = 2'b10
  } drsc_grade_e;
endpackage

// ---- verilog/drsc_rank.sv ----
// One rank: bank state, mode registers, power state
`timescale 1ns/10ps
`include "drsc_cfg.svh"
module drsc_rank (
  input wire logic clk,
  input wire logic reset,
  input wire logic resetAsyncN,
  input wire logic chipSelN,
  input wire logic clkEn,
  input wire logic termEn,
  input wire logic [2:0] cmdStrobes,
  input wire logic [`DRSC_BANK_W-1:0] bankSel,
  input wire logic [`DRSC_ROW_W-1:0] addr,
  input wire logic wideX4,
  output logic cmdValid,
  output logic [2:0] cmdCode,
  output logic [`DRSC_BANK_W-1:0] cmdBank,
  output logic [`DRSC_ROW_W-1:0] cmdRow,
  output logic [`DRSC_COL_W-1:0] cmdCol,
  output logic cmdAutoPre,
  output logic [3:0] cmdBurstLen,
  output logic [`DRSC_BANKS-1:0] bankOpen,
  output logic [2:0] pwrState,
  output logic rxEnable,
  output logic termActive,
  output logic [`DRSC_ROW_W-1:0] mr0Value,
  output logic [`DRSC_ROW_W-1:0] mr1Value,
  output logic [`DRSC_ROW_W-1:0] mr2Value,
  output logic [`DRSC_ROW_W-1:0] mr3Value
);
  // Registered state
  logic [`DRSC_BANKS-1:0] open_reg;
  logic [`DRSC_ROW_W-1:0] mr_reg [0:`DRSC_MR_COUNT-1];
  drsc_pkg::drsc_pwr_e pwr_reg;
  drsc_pkg::drsc_pwr_e pwr_next;
  logic cke_reg;
  // Self refresh exit seen without clock
  logic srExitAsync;
  logic srExitSync1;
  logic srExitSync2;

  // Decode
  wire inPowerDown = (pwr_reg != drsc_pkg::PS_ACTIVE);
  wire selected = !chipSelN && !inPowerDown && clkEn && cke_reg;
  wire [2:0] cmd = selected ? cmdStrobes : drsc_pkg::CMD_NOP;
  wire isAct = (cmd == drsc_pkg::CMD_ACT);
  wire isRd = (cmd == drsc_pkg::CMD_RD);
  wire isWr = (cmd == drsc_pkg::CMD_WR);
  wire isPre = (cmd == drsc_pkg::CMD_PRE);
  wire isMrs = (cmd == drsc_pkg::CMD_MRS);
  wire isRef = (cmd == drsc_pkg::CMD_REF);
  wire autoPre = addr[`DRSC_AP_BIT];
  wire otfEn = (mr_reg[0][`DRSC_MR0_BCOTF_HI:`DRSC_MR0_BCOTF_LO] == `DRSC_MR0_BCOTF_VAL);
  // High is eight beats; low chops to four only when MR0 enables on-the-fly
  wire [3:0] burstLen = (otfEn && !addr[`DRSC_BC_BIT]) ? `DRSC_BC4 : `DRSC_BL8;
  // Column from A[11,9:0] for x4, A[9:0] for x8
  wire [`DRSC_COL_W-1:0] colAddr = wideX4 ?
    {addr[`DRSC_COL_HI_BIT], addr[9:0]} : {1'b0, addr[9:0]};
  wire allIdle = (open_reg == '0);

  // Bank open and close per bank
  genvar gb;
  generate
    for (gb = 0; gb < `DRSC_BANKS; gb = gb + 1) begin : g_bank
      wire hit = (int'(bankSel) == gb);
      wire opens = isAct && hit;
      // Single bank or all banks on A10
      wire closes = (isPre && (autoPre || hit))
        || ((isRd || isWr) && hit && autoPre);
      always_ff @(posedge clk) begin
        if (reset || !resetAsyncN) begin
          open_reg[gb] <= 1'b0;
        end else if (opens) begin
          open_reg[gb] <= 1'b1;
        end else if (closes) begin
          open_reg[gb] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mode register writes, BA picks the register
  always_ff @(posedge clk) begin
    if (reset || !resetAsyncN) begin
      for (int i = 0; i < `DRSC_MR_COUNT; i++) begin
        mr_reg[i] <= `DRSC_MR0_RESET;
      end
    end else if (isMrs && bankSel[2] == 1'b0) begin
      mr_reg[bankSel[1:0]] <= addr;
    end
  end

  // Exit latch armed only in self refresh, so no stale edge carries over
  wire srArmN = resetAsyncN && (pwr_reg == drsc_pkg::PS_SELF_REF);

  // Self refresh exit: latched on CKE rising without clock
  always_ff @(posedge clkEn or negedge srArmN) begin
    if (!srArmN) begin
      srExitAsync <= 1'b0;
    end else begin
      srExitAsync <= 1'b1;
    end
  end

  // Synchroniser for the async exit
  always_ff @(posedge clk) begin
    if (reset || pwr_reg != drsc_pkg::PS_SELF_REF) begin
      srExitSync1 <= 1'b0;
      srExitSync2 <= 1'b0;
    end else begin
      srExitSync1 <= srExitAsync;
      srExitSync2 <= srExitSync1;
    end
  end

  // Power state selection
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      drsc_pkg::PS_ACTIVE: begin
        if (!clkEn && cke_reg) begin
          // Entry on a registered CKE fall only, so reset values do not enter
          // Entry is synchronous; REF with CKE low and all banks idle is self refresh
          if (!allIdle) begin
            pwr_next = drsc_pkg::PS_ACT_PD;
          end else if (!chipSelN && cmdStrobes == drsc_pkg::CMD_REF) begin
            pwr_next = drsc_pkg::PS_SELF_REF;
          end else begin
            pwr_next = drsc_pkg::PS_PRE_PD;
          end
        end
      end
      drsc_pkg::PS_PRE_PD, drsc_pkg::PS_ACT_PD: begin
        if (clkEn) begin
          pwr_next = drsc_pkg::PS_ACTIVE;
        end
      end
      drsc_pkg::PS_SELF_REF: begin
        if (srExitSync2 && clkEn) begin
          pwr_next = drsc_pkg::PS_ACTIVE;
        end
      end
      default: begin
        pwr_next = drsc_pkg::PS_ACTIVE;
      end
    endcase
  end

  // Power state and CKE registers
  always_ff @(posedge clk) begin
    if (reset || !resetAsyncN) begin
      pwr_reg <= drsc_pkg::PS_ACTIVE;
      cke_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      cke_reg <= clkEn;
    end
  end

  // Command outputs
  always_ff @(posedge clk) begin
    if (reset || !resetAsyncN) begin
      cmdValid <= 1'b0;
      cmdCode <= drsc_pkg::CMD_NOP;
      cmdBank <= '0;
      cmdRow <= '0;
      cmdCol <= '0;
      cmdAutoPre <= 1'b0;
      cmdBurstLen <= `DRSC_BL8;
      termActive <= 1'b0;
      rxEnable <= 1'b1;
    end else begin
      cmdValid <= isAct || isRd || isWr || isPre || isMrs || isRef;
      cmdCode <= cmd;
      cmdBank <= bankSel;
      cmdRow <= isAct ? addr : cmdRow;
      cmdCol <= (isRd || isWr) ? colAddr : cmdCol;
      cmdAutoPre <= (isRd || isWr || isPre) && autoPre;
      cmdBurstLen <= (isRd || isWr) ? burstLen : cmdBurstLen;
      // ODT receiver off in self refresh only
      termActive <= termEn && (pwr_next != drsc_pkg::PS_SELF_REF);
      // Receivers on only while the rank is active
      rxEnable <= (pwr_next == drsc_pkg::PS_ACTIVE);
    end
  end

  // Visible state
  assign bankOpen = open_reg;
  assign pwrState = pwr_reg;
  assign mr0Value = mr_reg[0];
  assign mr1Value = mr_reg[1];
  assign mr2Value = mr_reg[2];
  assign mr3Value = mr_reg[3];
endmodule

// ---- verilog/drsc_port.sv ----
// Top: two ranks of command, address and clock-enable logic
`timescale 1ns/10ps
`include "drsc_cfg.svh"
module drsc_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic resetN,
  input wire logic [`DRSC_RANKS-1:0] chipSelN,
  input wire logic [`DRSC_RANKS-1:0] clkEn,
  input wire logic [`DRSC_RANKS-1:0] termEn,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnN,
  input wire logic [`DRSC_BANK_W-1:0] bankSel,
  input wire logic [`DRSC_ROW_W-1:0] addr,
  input wire logic wideX4,
  input wire logic [1:0] speedGrade,
  output logic [`DRSC_RANKS-1:0] cmdValid,
  output logic [5:0] cmdCode,
  output logic [5:0] cmdBank,
  output logic [31:0] cmdRow,
  output logic [21:0] cmdCol,
  output logic [`DRSC_RANKS-1:0] cmdAutoPre,
  output logic [7:0] cmdBurstLen,
  output logic [15:0] bankOpen,
  output logic [5:0] pwrState,
  output logic [`DRSC_RANKS-1:0] rxEnable,
  output logic [`DRSC_RANKS-1:0] termActive,
  output logic [4:0] readLatency,
  output logic [4:0] actToAccessDelay,
  output logic [4:0] prechargePeriod
);
  // Registered pins, taken on the rising edge
  logic [`DRSC_RANKS-1:0] csN_reg;
  logic [`DRSC_RANKS-1:0] cke_reg;
  logic [`DRSC_RANKS-1:0] odt_reg;
  logic [2:0] strb_reg;
  logic [`DRSC_BANK_W-1:0] ba_reg;
  logic [`DRSC_ROW_W-1:0] a_reg;
  // Reset release, two-flop synchroniser
  logic rstSync1_reg;
  logic rstSync2_reg;
  // Latency for selected grade
  wire [4:0] latSel = (speedGrade == drsc_pkg::GR_1866) ? `DRSC_LAT_1866 :
                      (speedGrade == drsc_pkg::GR_1600) ? `DRSC_LAT_1600 :
                      `DRSC_LAT_1333;

  // Async low reset captured and released through two flops
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  wire coreRst = reset || !rstSync2_reg;

  // Input register stage
  always_ff @(posedge clk) begin
    if (coreRst) begin
      csN_reg <= '1;
      cke_reg <= '0;
      odt_reg <= '0;
      strb_reg <= drsc_pkg::CMD_NOP;
      ba_reg <= '0;
      a_reg <= '0;
    end else begin
      csN_reg <= chipSelN;
      cke_reg <= clkEn;
      odt_reg <= termEn;
      strb_reg <= {rowStrobeN, colStrobeN, writeEnN};
      ba_reg <= bankSel;
      a_reg <= addr;
    end
  end

  // Latency outputs
  always_ff @(posedge clk) begin
    if (coreRst) begin
      readLatency <= `DRSC_LAT_1333;
      actToAccessDelay <= `DRSC_LAT_1333;
      prechargePeriod <= `DRSC_LAT_1333;
    end else begin
      readLatency <= latSel;
      actToAccessDelay <= latSel;
      prechargePeriod <= latSel;
    end
  end

  // Two independent ranks
  genvar gr;
  generate
    for (gr = 0; gr < `DRSC_RANKS; gr = gr + 1) begin : g_rank
      drsc_rank u_rank (
        .clk(clk),
        .reset(coreRst),
        .resetAsyncN(rstSync2_reg),
        .chipSelN(csN_reg[gr]),
        .clkEn(cke_reg[gr]),
        .termEn(odt_reg[gr]),
        .cmdStrobes(strb_reg),
        .bankSel(ba_reg),
        .addr(a_reg),
        .wideX4(wideX4),
        .cmdValid(cmdValid[gr]),
        .cmdCode(cmdCode[3*gr+:3]),
        .cmdBank(cmdBank[3*gr+:3]),
        .cmdRow(cmdRow[16*gr+:16]),
        .cmdCol(cmdCol[11*gr+:11]),
        .cmdAutoPre(cmdAutoPre[gr]),
        .cmdBurstLen(cmdBurstLen[4*gr+:4]),
        .bankOpen(bankOpen[8*gr+:8]),
        .pwrState(pwrState[3*gr+:3]),
        .rxEnable(rxEnable[gr]),
        .termActive(termActive[gr]),
        .mr0Value(),
        .mr1Value(),
        .mr2Value(),
        .mr3Value()
      );
    end
  endgenerate
endmodule

// ---- bench/drsc_port_checker.sv ----
// Assertions on the command port outputs against the pins that caused them
`timescale 1ns/10ps
module drsc_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] chipSelN,
  input wire logic [1:0] clkEn,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnN,
  input wire logic [2:0] bankSel,
  input wire logic [15:0] addr,
  input wire logic [1:0] speedGrade,
  input wire logic [1:0] cmdValid,
  input wire logic [5:0] cmdCode,
  input wire logic [5:0] cmdBank,
  input wire logic [31:0] cmdRow,
  input wire logic [1:0] cmdAutoPre,
  input wire logic [15:0] bankOpen,
  input wire logic [5:0] pwrState,
  input wire logic [1:0] rxEnable,
  input wire logic [4:0] readLatency
);
  // All checks on the one clock, quiet in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  cs_gate_a: assert property (cmdValid[0] |-> !$past(chipSelN[0], 2))
    else $error("command taken while deselected");
  cke_gate_a: assert property (cmdValid[0] |-> $past(clkEn[0], 2))
    else $error("command taken with clock enable low");
  code_match_a: assert property (cmdValid[0] |->
    cmdCode[2:0] == {$past(rowStrobeN, 2), $past(colStrobeN, 2), $past(writeEnN, 2)})
    else $error("command code differs from strobes");
  bank_match_a: assert property (cmdValid[0] |-> cmdBank[2:0] == $past(bankSel, 2))
    else $error("command bank differs from bank select");
  act_row_a: assert property (cmdValid[0] && cmdCode[2:0] == 3'b011 |->
    cmdRow[15:0] == $past(addr, 2)) else $error("row address wrong");
  bank_open_a: assert property (cmdValid[0] && cmdCode[2:0] == 3'b011 |->
    bankOpen[cmdBank[2:0]]) else $error("activated bank not open");
  auto_pre_a: assert property (cmdValid[0] && cmdCode[2:1] == 2'b10 |->
    cmdAutoPre[0] == $past(addr[10], 2)) else $error("auto precharge bit wrong");
  pre_all_a: assert property (cmdValid[0] && cmdCode[2:0] == 3'b010 &&
    $past(addr[10], 2) |-> bankOpen[7:0] == 8'h00) else $error("banks left open");
  rx_off_a: assert property (pwrState[2:0] != 3'd0 |-> !rxEnable[0])
    else $error("receivers on in low power");
  grade_fast_a: assert property ((speedGrade == 2'd2) [*3] |-> readLatency == 5'h0D)
    else $error("fast grade latency wrong");
endmodule
bind drsc_port drsc_port_checker u_chk (.clk(clk), .reset(reset), .chipSelN(chipSelN),
  .clkEn(clkEn), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN),
  .bankSel(bankSel), .addr(addr), .speedGrade(speedGrade), .cmdValid(cmdValid),
  .cmdCode(cmdCode), .cmdBank(cmdBank), .cmdRow(cmdRow), .cmdAutoPre(cmdAutoPre),
  .bankOpen(bankOpen), .pwrState(pwrState), .rxEnable(rxEnable), .readLatency(readLatency));

// ---- bench/drsc_ctrl_model.sv ----
// Controller-side driver of command, address and clock-enable pins
`timescale 1ns/10ps
module drsc_ctrl_model (
  input wire logic clk,
  output logic [1:0] chipSelN,
  output logic [1:0] clkEn,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeEnN,
  output logic [2:0] bankSel,
  output logic [15:0] addr
);
  // Idle: both ranks deselected, clock enabled
  initial begin
    chipSelN = 2'b11;
    clkEn = 2'b11;
    {rowStrobeN, colStrobeN, writeEnN} = 3'b111;
    bankSel = 3'h0;
    addr = 16'h0000;
  end
  // One command for one cycle; clock enable stays where it is left
  task automatic issue(input logic r, input logic [2:0] cmd, input logic [2:0] ba,
      input logic [15:0] a, input logic cke);
    @(negedge clk);
    chipSelN[r] = 1'b0;
    clkEn[r] = cke;
    {rowStrobeN, colStrobeN, writeEnN} = cmd;
    bankSel = ba;
    addr = a;
    @(negedge clk);
    // Deselected lines carry the inverse of the last value
    chipSelN = 2'b11;
    {rowStrobeN, colStrobeN, writeEnN} = ~cmd;
    bankSel = ~ba;
    addr = ~a;
  endtask
endmodule

// ---- bench/test_dual_rank_sdram_cmd_addr_port.sv ----
// Self-checking bench for the dual-rank command and address port
`timescale 1ns/10ps
module test_dual_rank_sdram_cmd_addr_port;
  logic clk, reset, resetN, wideX4, rowStrobeN, colStrobeN, writeEnN, r;
  logic [1:0] termEn, speedGrade, chipSelN, clkEn, cmdValid, cmdAutoPre, rxEnable, termActive;
  logic [2:0] bankSel, ba;
  logic [15:0] addr, bankOpen, a, expOpen;
  logic [5:0] cmdCode, cmdBank, pwrState;
  logic [31:0] cmdRow;
  logic [21:0] cmdCol;
  logic [7:0] cmdBurstLen;
  logic [4:0] readLatency, actToAccessDelay, prechargePeriod;
  integer numErrors = 0, testsRun = 0, seed = 16, cycles = 0, i;
  drsc_port u_dut (.clk(clk), .reset(reset), .resetN(resetN), .chipSelN(chipSelN),
    .clkEn(clkEn), .termEn(termEn), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .writeEnN(writeEnN), .bankSel(bankSel), .addr(addr), .wideX4(wideX4),
    .speedGrade(speedGrade), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdBank(cmdBank),
    .cmdRow(cmdRow), .cmdCol(cmdCol), .cmdAutoPre(cmdAutoPre), .cmdBurstLen(cmdBurstLen),
    .bankOpen(bankOpen), .pwrState(pwrState), .rxEnable(rxEnable), .termActive(termActive),
    .readLatency(readLatency), .actToAccessDelay(actToAccessDelay),
    .prechargePeriod(prechargePeriod));
  drsc_ctrl_model u_ctrl (.clk(clk), .chipSelN(chipSelN), .clkEn(clkEn),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN),
    .bankSel(bankSel), .addr(addr));
  // Clock of 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      numErrors = numErrors + 1;
      wrapUp();
    end
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    testsRun = testsRun + 1;
    if (seen !== exp) begin
      numErrors = numErrors + 1;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // Latency in clocks for a grade
  function automatic logic [4:0] expLat(input logic [1:0] g);
    return (g == 2'd2) ? 5'h0D : ((g == 2'd1) ? 5'h0B : 5'h09);
  endfunction
  // Send a command and check its decode in the one cycle it stands
  task automatic doCmd(input logic rk, input logic [2:0] cmd, input logic [2:0] b,
      input logic [15:0] ad);
    u_ctrl.issue(rk, cmd, b, ad, 1'b1);
    @(negedge clk);
    check(cmdValid, 2'b01 << rk, "valid");
    check(cmdCode[3*rk+:3], cmd, "code");
    check(cmdBank[3*rk+:3], b, "bank");
  endtask
  // Wait a bounded time for a power state
  task automatic waitPwr(input logic rk, input logic [2:0] p);
    for (i = 0; i < 12 && pwrState[3*rk+:3] !== p; i++) @(negedge clk);
    check(pwrState[3*rk+:3], p, "power state");
    check(rxEnable[rk], p == 3'd0, "receivers");
  endtask
  // Verdict
  task automatic wrapUp;
    $display("Counts: %0d checks, %0d mismatches", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    resetN = 1'b0;
    wideX4 = 1'b0;
    termEn = 2'b11;
    speedGrade = 2'd0;
    expOpen = 16'h0000;
    @(negedge clk);
    resetN = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    for (int g = 0; g < 3; g++) begin
      speedGrade = g[1:0];
      repeat (3) @(negedge clk);
      check({readLatency, actToAccessDelay, prechargePeriod}, {3{expLat(g[1:0])}}, "lat");
    end
    $display("grades done");
    repeat (16) begin
      r = 1'($random(seed));
      ba = 3'($random(seed));
      a = 16'($random(seed));
      doCmd(r, drsc_pkg::CMD_ACT, ba, a);
      expOpen[{r, ba}] = 1'b1;
      check(cmdRow[16*r+:16], a, "row");
      check(bankOpen, expOpen, "open banks");
    end
    $display("activates done");
    doCmd(1'b0, drsc_pkg::CMD_MRS, 3'h0, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wideX4 = k[0];
      a = 16'($random(seed));
      a[12] = k[1];
      a[10] = k[0] & k[1];
      doCmd(1'b0, drsc_pkg::CMD_ACT, 3'h0, 16'h0100);
      doCmd(1'b0, k[1] ? drsc_pkg::CMD_RD : drsc_pkg::CMD_WR, 3'h0, a);
      check(cmdCol[10:0], {k[0] & a[11], a[9:0]}, "column");
      check(cmdBurstLen[3:0], a[12] ? 4'h8 : 4'h4, "burst");
      check(cmdAutoPre[0], a[10], "auto precharge");
    end
    $display("accesses done");
    doCmd(1'b0, drsc_pkg::CMD_ACT, 3'h6, 16'h0022);
    doCmd(1'b0, drsc_pkg::CMD_PRE, 3'h6, 16'h0000);
    check(bankOpen[6], 1'b0, "single close");
    doCmd(1'b0, drsc_pkg::CMD_PRE, 3'h2, 16'h0400);
    doCmd(1'b1, drsc_pkg::CMD_PRE, 3'h5, 16'h0400);
    check(bankOpen, 16'h0000, "all closed");
    $display("precharge done");
    u_ctrl.issue(1'b0, drsc_pkg::CMD_NOP, 3'h0, 16'h0000, 1'b0);
    waitPwr(1'b0, 3'd1);
    u_ctrl.issue(1'b0, drsc_pkg::CMD_ACT, 3'h1, 16'h0000, 1'b0);
    @(negedge clk);
    check(cmdValid, 2'b00, "refused in power-down");
    u_ctrl.issue(1'b0, drsc_pkg::CMD_NOP, 3'h0, 16'h0000, 1'b1);
    waitPwr(1'b0, 3'd0);
    doCmd(1'b1, drsc_pkg::CMD_ACT, 3'h2, 16'h0033);
    u_ctrl.issue(1'b1, drsc_pkg::CMD_NOP, 3'h0, 16'h0000, 1'b0);
    waitPwr(1'b1, 3'd2);
    u_ctrl.issue(1'b1, drsc_pkg::CMD_NOP, 3'h0, 16'h0000, 1'b1);
    waitPwr(1'b1, 3'd0);
    u_ctrl.issue(1'b0, drsc_pkg::CMD_REF, 3'h0, 16'h0000, 1'b0);
    waitPwr(1'b0, 3'd3);
    check(termActive, 2'b10, "termination in self refresh");
    u_ctrl.issue(1'b0, drsc_pkg::CMD_NOP, 3'h0, 16'h0000, 1'b1);
    waitPwr(1'b0, 3'd0);
    $display("power done");
    wrapUp();
  end
endmodule
